/* File: design/pws_pkg.sv */
/*
 * Constants shared by the programming word store: header layout, block codes,
 * word counts per block, reset values and timing figures.
 * Assumes a single 20 MHz device clock.
 */
package pws_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned READY_MAX_US = 250;
    localparam int unsigned READY_MAX_CYCLES = READY_MAX_US * (CLK_HZ / 1_000_000);

    // ---------------------------------------------------------------
    // Word header layout
    // ---------------------------------------------------------------
    localparam int unsigned HDR_FIRST_BIT = 15;
    localparam int unsigned HDR_SHORT_BIT = 14;
    localparam int unsigned HDR_BLK_MSB = 13;
    localparam int unsigned HDR_BLK_LSB = 12;
    localparam logic [1:0] BLK_MODEM = 2'h0;
    localparam logic [1:0] BLK_TONE = 2'h1;
    localparam logic [1:0] BLK_SUBAUDIO = 2'h2;
    localparam logic [1:0] BLK_RESERVED = 2'h3;

    // ---------------------------------------------------------------
    // Word counts per block
    // ---------------------------------------------------------------
    localparam logic [3:0] B0_WORDS = 4'h8;
    localparam logic [3:0] B1_WORDS = 4'h6;
    localparam logic [3:0] B4_WORDS = 4'h9;
    localparam int unsigned B4_STORED = 8;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] FRAME_SYNC_RESET = 16'hCB23;
    localparam logic [15:0] BIT_SYNC_RESET = 16'h5555;

    // ---------------------------------------------------------------
    // Four-tone lengths in ms, by code
    // ---------------------------------------------------------------
    localparam logic [7:0] TONE_MS_0 = 8'h28;
    localparam logic [7:0] TONE_MS_1 = 8'h3C;
    localparam logic [7:0] TONE_MS_2 = 8'h50;
    localparam logic [7:0] TONE_MS_3 = 8'h64;

    // Scramble seed select codes
    localparam logic [1:0] SCR_SEED_ONE = 2'h1;
    localparam logic [1:0] SCR_SEED_TWO = 2'h2;

    typedef enum logic [1:0] {ST_READY, ST_APPLY, ST_DONE} pws_state_e;

endpackage

/* File: design/pws_store.sv */
/*
 * Programming word decoder and configuration store.
 * Assumes the host writes one 16-bit word per i_wr_strobe pulse, only while
 * o_prog_ready is high; mode inputs and received bits are synchronous to i_clk.
 */
// Operation
// (RULE1) Bit 15 marks a first word; bit 14 low selects block 4, else bits 13:12.
// (RULE2) Ready flag drops on each write, returns once applied, well within 250 us.
// (RULE3) Host writes block words in order from the first; may stop early.
// (RULE4) Block 0 words 0 and 1 low bytes form the frame sync pattern.
// (RULE5) Sync search compares sync MSB bit 7 with the earliest received bit.
// (RULE6) Reset loads frame sync pattern with CB23.
// (RULE7) Data after a frame head is scrambled with the selected two-word seed.
// (RULE8) A selected seed of zero disables scrambling.
// (RULE9) Both ends of a link must program identical seeds.
// (RULE10) Block 0 words 6 and 7 hold the bit sync pattern, reset 5555.
// (RULE11) Host keeps the tone transmit level within 0 to 1536.
// (RULE12) Block 1 word 0 bit 0 selects tone detector de-emphasis.
// (RULE13) De-emphasis needs voice enable, emphasis enable and the select bit.
// (RULE14) Block 1 word 1 bits 11:10 give tone length 40/60/80/100 ms.
// (RULE15) Receive silent prefix and suffix must last at least the tone length.
// (RULE16) A received tone of twice the tone length or more is rejected.
// (RULE17) Block 1 word 1 bits 9:4 set the minimum detect level.
// (RULE18) Block 1 word 1 bits 3:0 select the detector bandwidth.
// (RULE19) Programmable tone words hold N and R in bits 10:0.
// (RULE20) Host computes the remainder R and rounds it.
// (RULE21) Host programs tones only between 400 and 3000 Hz.
// (RULE22) Host never writes block 3.
// (RULE23) Block 4 has nine 14-bit words; word 1 zero, word 8 test only.
// (RULE24) Per-block word counter restarts on a first word and routes payloads.
`timescale 1ns/10ps
module pws_store
    import pws_pkg::*;
#(
    parameter int unsigned P_READY_MAX_CYCLES = READY_MAX_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wr_strobe,
    input wire logic [15:0] i_wr_data,
    input wire logic i_voice_enable,
    input wire logic i_emph_enable,
    input wire logic [1:0] i_scramble_sel,
    input wire logic i_rx_bit,
    input wire logic i_rx_bit_valid,
    output logic o_prog_ready,
    output logic [15:0] o_frame_sync,
    output logic [15:0] o_seed_one,
    output logic [15:0] o_seed_two,
    output logic [15:0] o_bit_sync,
    output logic [15:0] o_active_seed,
    output logic o_scramble_on,
    output logic o_sync_found,
    output logic [10:0] o_tone_level,
    output logic o_emph_select,
    output logic o_tone_deemph,
    output logic [1:0] o_tone_len_code,
    output logic [7:0] o_tone_len_ms,
    output logic [8:0] o_tone_reject_ms,
    output logic [5:0] o_detect_threshold,
    output logic [3:0] o_detect_bandwidth,
    output logic [10:0] o_tone_one,
    output logic [10:0] o_tone_two,
    output logic [10:0] o_tone_three,
    output logic [10:0] o_tone_four,
    output logic [13:0] o_fine_input_gain,
    output logic [13:0] o_fine_output_gain_one,
    output logic [13:0] o_fine_output_gain_two,
    output logic [13:0] o_output_one_offset,
    output logic [13:0] o_output_two_offset,
    output logic [13:0] o_ramp_rate,
    output logic [13:0] o_soft_limiter
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Slot of the incoming word and the counter value after it
    function automatic logic [3:0] slot_of(input logic first, input logic [3:0] cnt);
        slot_of = first ? 4'h0 : cnt;
    endfunction

    function automatic logic [3:0] count_after(input logic first, input logic [3:0] cnt,
                                               input logic [3:0] limit);
        logic [3:0] slot;
        slot = slot_of(first, cnt);
        count_after = (slot < limit) ? slot + 4'h1 : limit;
    endfunction

    function automatic logic [7:0] tone_ms(input logic [1:0] code);
        unique case (code)
            2'h0: tone_ms = TONE_MS_0;
            2'h1: tone_ms = TONE_MS_1;
            2'h2: tone_ms = TONE_MS_2;
            2'h3: tone_ms = TONE_MS_3;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    pws_state_e state_reg;
    logic ready_reg;
    logic [15:0] word_reg;
    logic [3:0] cnt0_reg;
    logic [3:0] cnt1_reg;
    logic [3:0] cnt4_reg;
    logic [7:0] b0_mem [0:7];
    logic [11:0] b1_mem [0:5];
    logic [13:0] b4_mem [0:B4_STORED-1];
    logic [15:0] rx_shift_reg;
    logic [15:0] active_seed_reg;
    logic scramble_on_reg;
    logic sync_found_reg;
    logic deemph_reg;
    logic [7:0] tone_len_ms_reg;
    logic [8:0] tone_reject_ms_reg;

    // ---------------------------------------------------------------
    // Header decode
    // ---------------------------------------------------------------
    wire take = i_wr_strobe && ready_reg;
    wire applying = (state_reg == ST_APPLY);
    wire hdr_first = word_reg[HDR_FIRST_BIT];
    wire [1:0] hdr_blk = word_reg[HDR_BLK_MSB:HDR_BLK_LSB];
    // (RULE1) block select from header
    wire to_b4 = applying && !word_reg[HDR_SHORT_BIT];
    wire to_b0 = applying && word_reg[HDR_SHORT_BIT] && (hdr_blk == BLK_MODEM);
    wire to_b1 = applying && word_reg[HDR_SHORT_BIT] && (hdr_blk == BLK_TONE);
    wire [3:0] slot0 = slot_of(hdr_first, cnt0_reg);
    wire [3:0] slot1 = slot_of(hdr_first, cnt1_reg);
    wire [3:0] slot4 = slot_of(hdr_first, cnt4_reg);
    wire wr_b0 = to_b0 && (slot0 < B0_WORDS);
    wire wr_b1 = to_b1 && (slot1 < B1_WORDS);
    // (RULE23) test word 8 is counted but not kept
    wire wr_b4 = to_b4 && (slot4 < 4'(B4_STORED));
    wire [15:0] seed_one = {b0_mem[3], b0_mem[2]};
    wire [15:0] seed_two = {b0_mem[5], b0_mem[4]};
    wire [15:0] seed_sel = (i_scramble_sel == SCR_SEED_ONE) ? seed_one :
                           (i_scramble_sel == SCR_SEED_TWO) ? seed_two : 16'h0000;
    wire [15:0] rx_next = {rx_shift_reg[14:0], i_rx_bit};

    // ---------------------------------------------------------------
    // Write handshake
    // ---------------------------------------------------------------
    // (RULE2) ready drops on take, returns two edges later
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= ST_READY;
            ready_reg <= 1'b1;
            word_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_READY: begin
                    if (take) begin
                        state_reg <= ST_APPLY;
                        ready_reg <= 1'b0;
                        word_reg <= i_wr_data;
                    end
                end
                ST_APPLY: state_reg <= ST_DONE;
                ST_DONE: begin
                    state_reg <= ST_READY;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Word counters
    // ---------------------------------------------------------------
    // (RULE24) restart on first word, saturate at block length
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt0_reg <= B0_WORDS;
            cnt1_reg <= B1_WORDS;
            cnt4_reg <= B4_WORDS;
        end else begin
            if (to_b0) cnt0_reg <= count_after(hdr_first, cnt0_reg, B0_WORDS);
            if (to_b1) cnt1_reg <= count_after(hdr_first, cnt1_reg, B1_WORDS);
            if (to_b4) cnt4_reg <= count_after(hdr_first, cnt4_reg, B4_WORDS);
        end
    end

    // ---------------------------------------------------------------
    // Block storage
    // ---------------------------------------------------------------
    // (RULE6) (RULE10) sync patterns take their reset values
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 8; i++) begin
                b0_mem[i] <= 8'h00;
            end
            b0_mem[0] <= FRAME_SYNC_RESET[7:0];
            b0_mem[1] <= FRAME_SYNC_RESET[15:8];
            b0_mem[6] <= BIT_SYNC_RESET[7:0];
            b0_mem[7] <= BIT_SYNC_RESET[15:8];
        end else if (wr_b0) begin
            // (RULE4) low byte of each modem word
            b0_mem[slot0[2:0]] <= word_reg[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 6; i++) begin
                b1_mem[i] <= 12'h000;
            end
        end else if (wr_b1) begin
            b1_mem[slot1[2:0]] <= word_reg[11:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < B4_STORED; i++) begin
                b4_mem[i] <= 14'h0000;
            end
        end else if (wr_b4) begin
            b4_mem[slot4[2:0]] <= word_reg[13:0];
        end
    end

    // ---------------------------------------------------------------
    // Derived controls
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            active_seed_reg <= 16'h0000;
            scramble_on_reg <= 1'b0;
            deemph_reg <= 1'b0;
            tone_len_ms_reg <= TONE_MS_0;
            tone_reject_ms_reg <= {1'b0, TONE_MS_0} << 1;
        end else begin
            // (RULE7) (RULE8) selected seed, zero seed means off
            active_seed_reg <= seed_sel;
            scramble_on_reg <= (seed_sel != 16'h0000);
            // (RULE13) all three conditions needed
            deemph_reg <= i_voice_enable && i_emph_enable && b1_mem[0][0];
            // (RULE14) (RULE15) (RULE16) tone length and reject limit
            tone_len_ms_reg <= tone_ms(b1_mem[1][11:10]);
            tone_reject_ms_reg <= {1'b0, tone_ms(b1_mem[1][11:10])} << 1;
        end
    end

    // ---------------------------------------------------------------
    // Frame sync search
    // ---------------------------------------------------------------
    // (RULE5) earliest bit ends up at bit 15, facing sync MSB bit 7
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rx_shift_reg <= 16'h0000;
            sync_found_reg <= 1'b0;
        end else begin
            sync_found_reg <= 1'b0;
            if (i_rx_bit_valid) begin
                rx_shift_reg <= rx_next;
                sync_found_reg <= (rx_next == {b0_mem[1], b0_mem[0]});
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign o_prog_ready = ready_reg;
    assign o_frame_sync = {b0_mem[1], b0_mem[0]};
    assign o_seed_one = {b0_mem[3], b0_mem[2]};
    assign o_seed_two = {b0_mem[5], b0_mem[4]};
    assign o_bit_sync = {b0_mem[7], b0_mem[6]};
    assign o_active_seed = active_seed_reg;
    assign o_scramble_on = scramble_on_reg;
    assign o_sync_found = sync_found_reg;
    // (RULE12) de-emphasis select bit
    assign o_emph_select = b1_mem[0][0];
    assign o_tone_level = b1_mem[0][11:1];
    assign o_tone_deemph = deemph_reg;
    assign o_tone_len_code = b1_mem[1][11:10];
    assign o_tone_len_ms = tone_len_ms_reg;
    assign o_tone_reject_ms = tone_reject_ms_reg;
    // (RULE17) (RULE18) threshold and bandwidth fields
    assign o_detect_threshold = b1_mem[1][9:4];
    assign o_detect_bandwidth = b1_mem[1][3:0];
    // (RULE19) tone words carry N and R in bits 10:0
    assign o_tone_one = b1_mem[2][10:0];
    assign o_tone_two = b1_mem[3][10:0];
    assign o_tone_three = b1_mem[4][10:0];
    assign o_tone_four = b1_mem[5][10:0];
    assign o_fine_input_gain = b4_mem[0];
    assign o_fine_output_gain_one = b4_mem[2];
    assign o_fine_output_gain_two = b4_mem[3];
    assign o_output_one_offset = b4_mem[4];
    assign o_output_two_offset = b4_mem[5];
    assign o_ramp_rate = b4_mem[6];
    assign o_soft_limiter = b4_mem[7];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    logic [12:0] busy_cnt_reg;
    always_ff @(posedge i_clk) begin
        if (i_reset || ready_reg) begin
            busy_cnt_reg <= 13'h0000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 13'h0001;
        end
    end

    sequence s_taken;
        take ##1 !ready_reg;
    endsequence
    sequence s_restored;
        !ready_reg ##1 !ready_reg ##1 ready_reg;
    endsequence

    property p_ready_cycle;
        s_taken |-> s_restored;
    endproperty
    a_ready_cycle: assert property (p_ready_cycle) // (RULE2)
        else $error("ready flag did not drop and return after a write");

    property p_ready_bound;
        busy_cnt_reg < 13'(P_READY_MAX_CYCLES);
    endproperty
    a_ready_bound: assert property (p_ready_bound) // (RULE2)
        else $error("ready flag low too long");

    property p_first_word_b0;
        take && i_wr_data[15:12] == 4'hC |-> ##2 o_frame_sync[7:0] == $past(i_wr_data[7:0], 2);
    endproperty
    a_first_word_b0: assert property (p_first_word_b0) // (RULE4)
        else $error("first modem word not stored in frame sync low byte");

    property p_b4_count;
        take && i_wr_data[15:14] == 2'h2 |-> ##2 cnt4_reg == 4'h1;
    endproperty
    a_b4_count: assert property (p_b4_count) // (RULE24)
        else $error("block 4 counter not restarted by first word");

    property p_no_scramble_zero;
        (seed_sel == 16'h0000) |=> !o_scramble_on;
    endproperty
    a_no_scramble_zero: assert property (p_no_scramble_zero) // (RULE8)
        else $error("scrambling on with zero seed");

    property p_deemph;
        ##1 o_tone_deemph == $past(i_voice_enable && i_emph_enable && b1_mem[0][0]);
    endproperty
    a_deemph: assert property (p_deemph) // (RULE13)
        else $error("de-emphasis enable mismatch");

    property p_sync_found;
        i_rx_bit_valid && rx_next == o_frame_sync |=> o_sync_found;
    endproperty
    a_sync_found: assert property (p_sync_found) // (RULE5)
        else $error("frame sync match missed");

    property p_reject_double;
        o_tone_reject_ms == {o_tone_len_ms, 1'b0};
    endproperty
    a_reject_double: assert property (p_reject_double) // (RULE16)
        else $error("reject limit is not twice the tone length");

    property p_block3_ignored;
        take && i_wr_data[14:12] == 3'h7 |-> ##2 $stable(o_frame_sync) && $stable(o_tone_level);
    endproperty
    a_block3_ignored: assert property (p_block3_ignored) // (RULE1)
        else $error("reserved block write changed storage");

endmodule

/* File: dv/pws_host.sv */
/*
 * Host controller model: writes one programming word per handshake.
 * Assumes the device drops its ready flag on a taken word and raises it again.
 */
`timescale 1ns/10ps
module pws_host (
    input wire logic i_clk,
    input wire logic i_ready,
    output logic o_wr_strobe,
    output logic [15:0] o_wr_data
);
    // Cycles the ready flag stayed low after the last taken word
    logic [7:0] busy_cycles;

    initial begin
        o_wr_strobe = 1'b0;
        o_wr_data = 16'h0000;
        busy_cycles = 8'h00;
    end

    // ---------------------------------------------------------------
    // Word write
    // ---------------------------------------------------------------
    // Early set keeps the strobe up one more cycle with other data
    task automatic write_word(input logic [15:0] w, input logic [15:0] junk,
                              input logic early);
        int n;
        n = 0;
        @(posedge i_clk);
        while (i_ready !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        o_wr_strobe <= 1'b1;
        o_wr_data <= w;
        @(posedge i_clk);
        o_wr_strobe <= early;
        o_wr_data <= early ? junk : ~w;
        @(posedge i_clk);
        o_wr_strobe <= 1'b0;
        o_wr_data <= ~(early ? junk : w);
        n = 0;
        while (i_ready !== 1'b1 && n < 100) begin
            n++;
            @(posedge i_clk);
        end
        busy_cycles = n[7:0];
    endtask
endmodule

/* File: dv/tb_programming_word_config_store.sv */
/*
 * Self-checking bench for the programming word store.
 * Assumes pws_store and the host model pws_host, one 20 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
module tb_programming_word_config_store import pws_pkg::*; ();
    typedef struct {
        logic wr;
        logic [15:0] word;
        logic [4:0] idx;
        logic [15:0] exp;
    } pws_row_s;

    logic i_clk, i_reset, i_voice_enable, i_emph_enable, i_rx_bit, i_rx_bit_valid;
    logic [1:0] i_scramble_sel;
    wire logic i_wr_strobe;
    wire logic [15:0] i_wr_data;
    logic o_prog_ready, o_scramble_on, o_sync_found, o_emph_select, o_tone_deemph;
    logic [15:0] o_frame_sync, o_seed_one, o_seed_two, o_bit_sync, o_active_seed;
    logic [10:0] o_tone_level, o_tone_one, o_tone_two, o_tone_three, o_tone_four;
    logic [1:0] o_tone_len_code;
    logic [7:0] o_tone_len_ms;
    logic [8:0] o_tone_reject_ms;
    logic [5:0] o_detect_threshold;
    logic [3:0] o_detect_bandwidth;
    logic [13:0] o_fine_input_gain, o_fine_output_gain_one, o_fine_output_gain_two;
    logic [13:0] o_output_one_offset, o_output_two_offset, o_ramp_rate, o_soft_limiter;
    int errors = 0;
    int checks_done = 0;
    logic [7:0] ms_tab [4] = '{8'h28, 8'h3C, 8'h50, 8'h64};

    // Blocks 0, 1 and 4 in order; rows without a write check another field
    pws_row_s rows [27] = '{
        '{1'b1, 16'hC0A5, 5'h00, 16'hCBA5}, '{1'b1, 16'h405A, 5'h00, 16'h5AA5},
        '{1'b1, 16'h4012, 5'h01, 16'h0012}, '{1'b1, 16'h4034, 5'h01, 16'h3412},
        '{1'b1, 16'h4056, 5'h02, 16'h0056}, '{1'b1, 16'h4078, 5'h02, 16'h7856},
        '{1'b1, 16'h40F0, 5'h03, 16'h55F0}, '{1'b1, 16'h400F, 5'h03, 16'h0FF0},
        '{1'b1, 16'hDC01, 5'h04, 16'h0600}, '{1'b0, 16'h0000, 5'h05, 16'h0001},
        '{1'b1, 16'h5EA9, 5'h06, 16'h0003}, '{1'b0, 16'h0000, 5'h07, 16'h002A},
        '{1'b0, 16'h0000, 5'h08, 16'h0009}, '{1'b0, 16'h0000, 5'h14, 16'h0064},
        '{1'b0, 16'h0000, 5'h15, 16'h00C8}, '{1'b1, 16'h52B1, 5'h09, 16'h02B1},
        '{1'b1, 16'h5111, 5'h0A, 16'h0111}, '{1'b1, 16'h57F2, 5'h0B, 16'h07F2},
        '{1'b1, 16'h52B1, 5'h0C, 16'h02B1}, '{1'b1, 16'h9234, 5'h0D, 16'h1234},
        '{1'b1, 16'h0000, 5'h0D, 16'h1234}, '{1'b1, 16'h3FFF, 5'h0E, 16'h3FFF},
        '{1'b1, 16'h0001, 5'h0F, 16'h0001}, '{1'b1, 16'h2AAA, 5'h10, 16'h2AAA},
        '{1'b1, 16'h1555, 5'h11, 16'h1555}, '{1'b1, 16'h0ABC, 5'h12, 16'h0ABC},
        '{1'b1, 16'h3FFF, 5'h13, 16'h3FFF}};

    pws_store #(.P_READY_MAX_CYCLES(4)) dut_u (.*);

    pws_host host_u (
        .i_clk(i_clk),
        .i_ready(o_prog_ready),
        .o_wr_strobe(i_wr_strobe),
        .o_wr_data(i_wr_data)
    );

    always #25 i_clk = ~i_clk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] get_out(input logic [4:0] idx);
        case (idx)
            5'h00: get_out = o_frame_sync;
            5'h01: get_out = o_seed_one;
            5'h02: get_out = o_seed_two;
            5'h03: get_out = o_bit_sync;
            5'h04: get_out = 16'(o_tone_level);
            5'h05: get_out = 16'(o_emph_select);
            5'h06: get_out = 16'(o_tone_len_code);
            5'h07: get_out = 16'(o_detect_threshold);
            5'h08: get_out = 16'(o_detect_bandwidth);
            5'h09: get_out = 16'(o_tone_one);
            5'h0A: get_out = 16'(o_tone_two);
            5'h0B: get_out = 16'(o_tone_three);
            5'h0C: get_out = 16'(o_tone_four);
            5'h0D: get_out = 16'(o_fine_input_gain);
            5'h0E: get_out = 16'(o_fine_output_gain_one);
            5'h0F: get_out = 16'(o_fine_output_gain_two);
            5'h10: get_out = 16'(o_output_one_offset);
            5'h11: get_out = 16'(o_output_two_offset);
            5'h12: get_out = 16'(o_ramp_rate);
            5'h13: get_out = 16'(o_soft_limiter);
            5'h14: get_out = 16'(o_tone_len_ms);
            5'h15: get_out = 16'(o_tone_reject_ms);
            default: get_out = 16'h0000;
        endcase
    endfunction

    task automatic wr(input logic [15:0] w);
        host_u.write_word(w, 16'h0000, 1'b0);
        `CHK(host_u.busy_cycles, 8'h02)
    endtask

    // Sends v earliest bit first, then checks the one-cycle match pulse
    task automatic feed(input logic [15:0] v, input logic exp);
        for (int k = 15; k >= 0; k--) begin
            @(posedge i_clk);
            i_rx_bit <= v[k];
            i_rx_bit_valid <= 1'b1;
        end
        @(posedge i_clk);
        i_rx_bit_valid <= 1'b0;
        i_rx_bit <= ~v[0];
        #1;
        `CHK(o_sync_found, exp)
        @(posedge i_clk);
        #1;
        `CHK(o_sync_found, 1'b0)
    endtask

    task automatic end_of_test();
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_500_000;
        errors++;
        end_of_test();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        i_reset = 1'b1;
        i_voice_enable = 1'b0;
        i_emph_enable = 1'b0;
        i_scramble_sel = 2'h0;
        i_rx_bit = 1'b0;
        i_rx_bit_valid = 1'b0;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        `CHK(o_frame_sync, 16'hCB23)
        `CHK(o_bit_sync, 16'h5555)
        `CHK(o_prog_ready, 1'b1)
        wr(16'h4077);
        `CHK(o_frame_sync, 16'hCB23)
        for (int i = 0; i < 27; i++) begin
            if (rows[i].wr) begin
                wr(rows[i].word);
            end
            `CHK(get_out(rows[i].idx), rows[i].exp)
        end
        for (int c = 0; c < 4; c++) begin
            wr(16'hDC01);
            wr({4'h5, c[1:0], 10'h2A9});
            `CHK(o_tone_len_code, c[1:0])
            `CHK(o_tone_len_ms, ms_tab[c])
            `CHK(o_tone_reject_ms, {ms_tab[c], 1'b0})
        end
        for (int m = 0; m < 4; m++) begin
            @(posedge i_clk);
            i_voice_enable <= m[0];
            i_emph_enable <= m[1];
            repeat (2) @(posedge i_clk);
            #1;
            `CHK(o_tone_deemph, (m == 3))
        end
        @(posedge i_clk);
        wr(16'hDC00);
        `CHK(o_emph_select, 1'b0)
        `CHK(o_tone_deemph, 1'b0)
        for (int s = 0; s < 4; s++) begin
            @(posedge i_clk);
            i_scramble_sel <= s[1:0];
            repeat (2) @(posedge i_clk);
            #1;
            `CHK(o_active_seed, (s == 1) ? 16'h3412 : (s == 2) ? 16'h7856 : 16'h0000)
            `CHK(o_scramble_on, (s == 1 || s == 2))
        end
        host_u.write_word(16'hC011, 16'hC099, 1'b1);
        `CHK(host_u.busy_cycles, 8'h02)
        `CHK(o_frame_sync, 16'h5A11)
        wr(16'hF0FF);
        wr(16'h70EE);
        wr(16'hE0AB);
        `CHK(o_frame_sync, 16'h5A11)
        `CHK(o_tone_level, 11'h600)
        feed(16'h5A11, 1'b1);
        feed(16'h885A, 1'b0);
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        i_scramble_sel <= 2'h1;
        @(posedge i_clk);
        #1;
        `CHK(o_frame_sync, 16'hCB23)
        `CHK(o_bit_sync, 16'h5555)
        `CHK(o_seed_one, 16'h0000)
        `CHK(o_tone_len_ms, 8'h28)
        `CHK(o_tone_reject_ms, 9'h050)
        `CHK(o_active_seed, 16'h0000)
        `CHK(o_scramble_on, 1'b0)
        `CHK(o_prog_ready, 1'b1)
        end_of_test();
    end
endmodule
